// file: rtl/hsr_pkg.sv
package hsr_pkg;

   // ---------------------------------------------------------------
   // Register offsets (7-bit byte addresses on the serial link)
   // ---------------------------------------------------------------
   localparam logic [6:0] OFS_DATA_FIRST = 7'h00;
   localparam logic [6:0] OFS_DATA_LAST  = 7'h0d;
   localparam logic [6:0] OFS_INT_STATUS = 7'h10;
   localparam logic [6:0] OFS_INT_CFG    = 7'h11;
   localparam logic [6:0] OFS_IRQ_LINE_ONE_EN    = 7'h12;
   localparam logic [6:0] OFS_IRQ_LINE_TWO_EN    = 7'h13;
   localparam logic [6:0] OFS_FS_CFG     = 7'h14;
   localparam logic [6:0] OFS_CLK_CFG    = 7'h15;
   localparam logic [6:0] OFS_SELFTEST   = 7'h16;
   localparam logic [6:0] OFS_IF_CFG     = 7'h17;

   // ---------------------------------------------------------------
   // Field positions and sizes
   // ---------------------------------------------------------------
   localparam int DATA_BYTES      = 14;
   localparam int NUM_SRC         = 5;
   localparam int CMD_RD_BIT      = 7;
   localparam int GFS_LSB         = 0;
   localparam int AFS_LSB         = 4;
   localparam int CLK_AUTO_BIT    = 0;
   localparam int IF_3WIRE_BIT    = 0;
   localparam int FIFO_TEMP_SHIFT = 6;
   localparam int SRC_CLK_LOCK    = 0;
   localparam int SRC_DATA_RDY    = 1;
   localparam int SRC_ACCEL_EVT   = 2;
   localparam int SRC_FIFO_WM     = 3;
   localparam int SRC_FIFO_OVF    = 4;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_INT_CFG  = 8'h0f;
   localparam logic [7:0] RST_INT_EN   = 8'h00;
   localparam logic [7:0] RST_FS_CFG   = 8'h00;
   localparam logic [7:0] RST_CLK_CFG  = 8'h01;
   localparam logic [7:0] RST_SELFTEST = 8'h00;
   localparam logic [7:0] RST_IF_CFG   = 8'h00;
   localparam logic [4:0] RST_SYNC     = 5'h01;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      GFS_2000 = 3'h0, GFS_1000 = 3'h1, GFS_500 = 3'h2, GFS_250 = 3'h3,
      GFS_125 = 3'h4, GFS_62P5 = 3'h5, GFS_31P25 = 3'h6, GFS_15P625 = 3'h7
   } hsr_gyro_fs_e;

   typedef enum logic [1:0] {
      AFS_16G = 2'h0, AFS_8G = 2'h1, AFS_4G = 2'h2, AFS_2G = 2'h3
   } hsr_accel_fs_e;

   typedef enum logic {
      CLK_RELAX_ONLY = 1'b0, CLK_AUTO_SEL = 1'b1
   } hsr_clk_src_e;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001, ST_CMD = 3'b010, ST_DATA = 3'b100
   } hsr_spi_state_e;

   typedef struct packed {
      logic [2:0] spare;
      logic       fsyncMode;
      logic       rdClear;
      logic       latched;
      logic       pushPull2;
      logic       pushPull1;
   } hsr_irq_cfg_s;

   typedef struct packed {
      logic signed [15:0] temp;
      logic signed [15:0] accelX;
      logic signed [15:0] accelY;
      logic signed [15:0] accelZ;
      logic signed [15:0] gyroX;
      logic signed [15:0] gyroY;
      logic signed [15:0] gyroZ;
   } hsr_sample_s;

endpackage : hsr_pkg

// file: rtl/hsr_data_regs.sv
`timescale 1ns/1ps
module hsr_data_regs (
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                srst,
   // Sample write side
   input  wire logic                wrEn,
   input  wire hsr_pkg::hsr_sample_s wrSample,
   // Byte read side
   input  wire logic [6:0]          rdAddr,
   output logic      [7:0]          rdData
);
   import hsr_pkg::*;

   logic [7:0] mem_r [DATA_BYTES];
   logic [7:0] rdData_nxt;

   // ---------------------------------------------------------------
   // Storage, whole sample written at once; a burst read that spans a write can mix samples
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < DATA_BYTES; gi++) begin : gByte
         always_ff @(posedge core_clk) begin
            if (srst) begin
               mem_r[gi] <= 8'h00;
            end else if (wrEn) begin
               mem_r[gi] <= wrSample[8*(DATA_BYTES-gi)-1 -: 8];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Registered read
   // ---------------------------------------------------------------
   always_comb begin
      rdData_nxt = 8'h00;
      if (rdAddr <= OFS_DATA_LAST) begin
         rdData_nxt = mem_r[rdAddr[3:0]];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdData <= 8'h00;
      end else begin
         rdData <= rdData_nxt;
      end
   end

endmodule : hsr_data_regs

// file: rtl/hsr_host_readout.sv
`timescale 1ns/1ps
// Behaviour
// - Device only answers as target; pins driven only while host reads from it.
// - Four-wire SPI drives read data on shared pin; two-wire samples it as address LSB.
// - Three-wire SPI: bidirectional data pin carries both directions; four-wire: input only.
// - Each interrupt pin is push-pull or open-drain by configuration.
// - All enabled interrupt sources combine onto interrupt line one.
// - Gyro full scale selects one of eight ranges, 15.625 to 2000 dps.
// - Accel full scale selects 2g, 4g, 8g or 16g.
// - Clock source is relaxation oscillator or automatic choice, automatic recommended.
// - Sensor data registers hold latest sample, read-only, readable any time.
// - Five interrupt sources: clock lock, data ready, accel event, watermark, overflow.
// - Software picks pin settings, trigger sources, latching and clearing method.
// - Readable interrupt status register shows which conditions occurred.
// - Register temperature is signed, 132.48 counts per degree, zero at 25 C.
// - FIFO temperature is eight bits, 2.07 counts per degree, zero at 25 C.
// - Self-test enabled per gyro and accel axis through self-test register.
module hsr_host_readout (
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  srst,
   // Host serial pins
   input  wire logic                  hostChipSelectN,
   input  wire logic                  hostSpiClock,
   input  wire logic                  hostBidirDataIn,
   output logic                       hostBidirDataOut,
   output logic                       hostBidirDataOe,
   input  wire logic                  addrLsbStrapIn,
   output logic                       hostSerialOut,
   output logic                       hostSerialOutOe,
   // Two-wire engine hand-off
   output logic                       twoWireMode,
   output logic                       addrLsbStrap,
   // Interrupt and frame sync pins
   output logic                       irqLineOneOut,
   output logic                       irqLineOneOe,
   output logic                       irqLineTwoOut,
   output logic                       irqLineTwoOe,
   input  wire logic                  frameSyncInput,
   output logic                       frameSyncPulse,
   // Sensor side
   input  wire hsr_pkg::hsr_sample_s  sample,
   input  wire logic                  sampleValid,
   input  wire logic [4:0]            irqEvent,
   output logic      [7:0]            fifoTempByte,
   // Configuration outputs
   output hsr_pkg::hsr_gyro_fs_e      gyroFsSel,
   output hsr_pkg::hsr_accel_fs_e     accelFsSel,
   output hsr_pkg::hsr_clk_src_e      clkSrcSel,
   output logic      [5:0]            selfTestEn
);
   import hsr_pkg::*;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [4:0] syncA_r, syncB_r;
   logic       sclkD_r, fsD_r;
   logic       csN, sclk, sdi, pin1, fs, rise, fall;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         syncA_r <= RST_SYNC;
         syncB_r <= RST_SYNC;
         sclkD_r <= 1'b0;
         fsD_r   <= 1'b0;
      end else begin
         syncA_r <= {frameSyncInput, addrLsbStrapIn, hostBidirDataIn, hostSpiClock, hostChipSelectN};
         syncB_r <= syncA_r;
         sclkD_r <= syncB_r[1];
         fsD_r   <= syncB_r[4];
      end
   end

   assign csN  = syncB_r[0];
   assign sclk = syncB_r[1];
   assign sdi  = syncB_r[2];
   assign pin1 = syncB_r[3];
   assign fs   = syncB_r[4];
   assign rise = sclk & ~sclkD_r & ~csN;
   assign fall = ~sclk & sclkD_r & ~csN;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   hsr_spi_state_e state_r, state_nxt;
   hsr_irq_cfg_s   intCfg_r, intCfg_nxt;
   logic [2:0] bitCnt_r, bitCnt_nxt;
   logic [7:0] shiftIn_r, shiftIn_nxt, txByte_r, txByte_nxt;
   logic [6:0] addr_r, addr_nxt;
   logic       isRead_r, isRead_nxt;
   logic [1:0] ldDly_r, ldDly_nxt;
   logic [4:0] status_r, status_nxt;
   logic [7:0] en1_r, en1_nxt, en2_r, en2_nxt, fsCfg_r, fsCfg_nxt;
   logic [7:0] clkCfg_r, clkCfg_nxt, selfTest_r, selfTest_nxt, ifCfg_r, ifCfg_nxt;
   logic       sdo_r, sdo_nxt, serOe_r, serOe_nxt, bidOe_r, bidOe_nxt;
   logic       twoWire_r, twoWire_nxt, lsb_r, lsb_nxt, fsP_r, fsP_nxt;
   logic       irq1Out_r, irq1Out_nxt, irq1Oe_r, irq1Oe_nxt;
   logic       irq2Out_r, irq2Out_nxt, irq2Oe_r, irq2Oe_nxt;
   logic [7:0] fifoTemp_r, fifoTemp_nxt;
   logic [7:0] sIn, rdByte, memRdData;
   logic [4:0] clrMask;
   logic       boundary, wrEn, lvl1, lvl2, readActive;
   logic signed [9:0] tempScaled;

   function automatic logic isDataAddr(input logic [6:0] a);
      isDataAddr = (a >= OFS_DATA_FIRST) && (a <= OFS_DATA_LAST);
   endfunction : isDataAddr

   hsr_data_regs uData (
      .core_clk (core_clk),
      .srst     (srst),
      .wrEn     (sampleValid),
      .wrSample (sample),
      .rdAddr   (addr_r),
      .rdData   (memRdData)
   );

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;   bitCnt_nxt = bitCnt_r; shiftIn_nxt = shiftIn_r;
      txByte_nxt = txByte_r; addr_nxt = addr_r;     isRead_nxt = isRead_r;
      intCfg_nxt = intCfg_r; en1_nxt = en1_r;       en2_nxt = en2_r;
      fsCfg_nxt = fsCfg_r;   clkCfg_nxt = clkCfg_r; selfTest_nxt = selfTest_r;
      ifCfg_nxt = ifCfg_r;   sdo_nxt = sdo_r;       fifoTemp_nxt = fifoTemp_r;
      boundary = 1'b0;
      wrEn = 1'b0;
      clrMask = 5'h00;
      sIn = {shiftIn_r[6:0], sdi};
      // Host framing; the device never starts a transfer itself
      if (csN) begin
         state_nxt  = ST_IDLE;
         bitCnt_nxt = 3'h0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               state_nxt = ST_CMD;
            end
            ST_CMD, ST_DATA: begin
               if (rise) begin
                  shiftIn_nxt = sIn;
                  bitCnt_nxt  = bitCnt_r + 3'h1;
                  if (bitCnt_r == 3'h7) begin
                     boundary = 1'b1;
                     if (state_r == ST_CMD) begin
                        isRead_nxt = sIn[CMD_RD_BIT];
                        addr_nxt   = sIn[6:0];
                        state_nxt  = ST_DATA;
                     end else begin
                        addr_nxt = addr_r + 7'h01;
                        wrEn     = ~isRead_r;
                     end
                  end
               end
            end
            default: begin
               state_nxt = ST_IDLE;
            end
         endcase
         if (fall && state_r == ST_DATA && isRead_r) begin
            sdo_nxt    = txByte_r[7];
            txByte_nxt = {txByte_r[6:0], 1'b0};
         end
      end
      // Read data fetched two cycles after the address settles, well before the next falling edge
      ldDly_nxt = {ldDly_r[0], boundary & ((state_r == ST_CMD) ? sIn[CMD_RD_BIT] : isRead_r)};
      case (addr_r)
         OFS_INT_STATUS: rdByte = {3'h0, status_r};
         OFS_INT_CFG:    rdByte = intCfg_r;
         OFS_IRQ_LINE_ONE_EN:    rdByte = en1_r;
         OFS_IRQ_LINE_TWO_EN:    rdByte = en2_r;
         OFS_FS_CFG:     rdByte = fsCfg_r;
         OFS_CLK_CFG:    rdByte = clkCfg_r;
         OFS_SELFTEST:   rdByte = selfTest_r;
         OFS_IF_CFG:     rdByte = ifCfg_r;
         default:        rdByte = isDataAddr(addr_r) ? memRdData : 8'h00;
      endcase
      if (ldDly_r[1]) begin
         txByte_nxt = rdByte;
         if (addr_r == OFS_INT_STATUS && intCfg_r.rdClear) begin
            clrMask = 5'h1f;
         end
      end
      // Writes to sensor data addresses fall through and are dropped
      if (wrEn) begin
         case (addr_r)
            OFS_INT_STATUS: clrMask = intCfg_r.rdClear ? 5'h00 : sIn[4:0];
            OFS_INT_CFG:    intCfg_nxt = hsr_irq_cfg_s'(sIn);
            OFS_IRQ_LINE_ONE_EN:    en1_nxt = sIn;
            OFS_IRQ_LINE_TWO_EN:    en2_nxt = sIn;
            OFS_FS_CFG:     fsCfg_nxt = sIn;
            OFS_CLK_CFG:    clkCfg_nxt = sIn;
            OFS_SELFTEST:   selfTest_nxt = sIn;
            OFS_IF_CFG:     ifCfg_nxt = sIn;
            default:        clrMask = 5'h00;
         endcase
      end
      // New events win over a clear in the same cycle
      status_nxt = (status_r & ~clrMask) | irqEvent;
      readActive = (state_r == ST_DATA) && isRead_r && !csN;
      serOe_nxt  = readActive && !twoWire_r && !ifCfg_r[IF_3WIRE_BIT];
      bidOe_nxt  = readActive && ifCfg_r[IF_3WIRE_BIT];
      // Chip select seen low once means the host speaks SPI from then on
      twoWire_nxt = twoWire_r & csN;
      lsb_nxt     = twoWire_r ? pin1 : lsb_r;
      lvl1 = intCfg_r.latched ? |(status_r & en1_r[4:0]) : |(irqEvent & en1_r[4:0]);
      lvl2 = intCfg_r.latched ? |(status_r & en2_r[4:0]) : |(irqEvent & en2_r[4:0]);
      // Open-drain pulls low while active; push-pull drives the level high-active
      irq1Out_nxt = intCfg_r.pushPull1 & lvl1;
      irq1Oe_nxt  = intCfg_r.pushPull1 | lvl1;
      irq2Out_nxt = !intCfg_r.fsyncMode && intCfg_r.pushPull2 && lvl2;
      irq2Oe_nxt  = !intCfg_r.fsyncMode && (intCfg_r.pushPull2 || lvl2);
      fsP_nxt     = intCfg_r.fsyncMode & fs & ~fsD_r;
      // 132.48 / 2.07 is exactly 64, so the FIFO byte is a saturated shift
      tempScaled = sample.temp[15:FIFO_TEMP_SHIFT];
      if (sampleValid) begin
         if (tempScaled > 10'sd127) begin
            fifoTemp_nxt = 8'h7f;
         end else if (tempScaled < -10'sd128) begin
            fifoTemp_nxt = 8'h80;
         end else begin
            fifoTemp_nxt = tempScaled[7:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_r <= ST_IDLE;   bitCnt_r <= 3'h0;      shiftIn_r <= 8'h00;
         txByte_r <= 8'h00;    addr_r <= 7'h00;       isRead_r <= 1'b0;
         ldDly_r <= 2'h0;      status_r <= 5'h00;     intCfg_r <= hsr_irq_cfg_s'(RST_INT_CFG);
         en1_r <= RST_INT_EN;  en2_r <= RST_INT_EN;   fsCfg_r <= RST_FS_CFG;
         clkCfg_r <= RST_CLK_CFG; selfTest_r <= RST_SELFTEST; ifCfg_r <= RST_IF_CFG;
         sdo_r <= 1'b0;        serOe_r <= 1'b0;       bidOe_r <= 1'b0;
         twoWire_r <= 1'b1;    lsb_r <= 1'b0;         fsP_r <= 1'b0;
         irq1Out_r <= 1'b0;    irq1Oe_r <= 1'b0;      irq2Out_r <= 1'b0;
         irq2Oe_r <= 1'b0;     fifoTemp_r <= 8'h00;
      end else begin
         state_r <= state_nxt;   bitCnt_r <= bitCnt_nxt;   shiftIn_r <= shiftIn_nxt;
         txByte_r <= txByte_nxt; addr_r <= addr_nxt;       isRead_r <= isRead_nxt;
         ldDly_r <= ldDly_nxt;   status_r <= status_nxt;   intCfg_r <= intCfg_nxt;
         en1_r <= en1_nxt;       en2_r <= en2_nxt;         fsCfg_r <= fsCfg_nxt;
         clkCfg_r <= clkCfg_nxt; selfTest_r <= selfTest_nxt; ifCfg_r <= ifCfg_nxt;
         sdo_r <= sdo_nxt;       serOe_r <= serOe_nxt;     bidOe_r <= bidOe_nxt;
         twoWire_r <= twoWire_nxt; lsb_r <= lsb_nxt;       fsP_r <= fsP_nxt;
         irq1Out_r <= irq1Out_nxt; irq1Oe_r <= irq1Oe_nxt; irq2Out_r <= irq2Out_nxt;
         irq2Oe_r <= irq2Oe_nxt; fifoTemp_r <= fifoTemp_nxt;
      end
   end

   assign hostSerialOut    = sdo_r;
   assign hostSerialOutOe  = serOe_r;
   assign hostBidirDataOut = sdo_r;
   assign hostBidirDataOe  = bidOe_r;
   assign twoWireMode      = twoWire_r;
   assign addrLsbStrap     = lsb_r;
   assign irqLineOneOut    = irq1Out_r;
   assign irqLineOneOe     = irq1Oe_r;
   assign irqLineTwoOut    = irq2Out_r;
   assign irqLineTwoOe     = irq2Oe_r;
   assign frameSyncPulse   = fsP_r;
   assign fifoTempByte     = fifoTemp_r;
   assign gyroFsSel        = hsr_gyro_fs_e'(fsCfg_r[GFS_LSB +: 3]);
   assign accelFsSel       = hsr_accel_fs_e'(fsCfg_r[AFS_LSB +: 2]);
   assign clkSrcSel        = hsr_clk_src_e'(clkCfg_r[CLK_AUTO_BIT]);
   assign selfTestEn       = selfTest_r[5:0];

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   property p_noDriveDeselected;
      csN && $past(csN) |-> !hostSerialOutOe && !hostBidirDataOe;
   endproperty
   a_noDriveDeselected: assert property (p_noDriveDeselected) else $error("pin driven while deselected");

   property p_twoWireNoSdo;
      twoWire_r |=> !hostSerialOutOe;
   endproperty
   a_twoWireNoSdo: assert property (p_twoWireNoSdo) else $error("shared pin driven in two-wire mode");

   property p_fourWireBidirInput;
      !ifCfg_r[IF_3WIRE_BIT] |=> !hostBidirDataOe;
   endproperty
   a_fourWireBidirInput: assert property (p_fourWireBidirInput) else $error("data pin driven in four-wire");

   property p_openDrainNeverHigh;
      !intCfg_r.pushPull1 |=> !irqLineOneOut;
   endproperty
   a_openDrainNeverHigh: assert property (p_openDrainNeverHigh) else $error("open-drain line driven high");

   property p_combinedLine;
      intCfg_r.latched && intCfg_r.pushPull1 && |(status_r & en1_r[4:0]) |=> irqLineOneOut;
   endproperty
   a_combinedLine: assert property (p_combinedLine) else $error("enabled status not on line one");

   property p_fsyncNoDrive;
      intCfg_r.fsyncMode |=> !irqLineTwoOe;
   endproperty
   a_fsyncNoDrive: assert property (p_fsyncNoDrive) else $error("frame sync pin driven");

   property p_eventSticky;
      irqEvent[SRC_DATA_RDY] |=> status_r[SRC_DATA_RDY];
   endproperty
   a_eventSticky: assert property (p_eventSticky) else $error("event not captured");

   property p_statusHolds;
      status_r[SRC_FIFO_OVF] && clrMask == 5'h00 |=> status_r[SRC_FIFO_OVF];
   endproperty
   a_statusHolds: assert property (p_statusHolds) else $error("status lost without clear");

   property p_readClear;
      ldDly_r[1] && addr_r == OFS_INT_STATUS && intCfg_r.rdClear && irqEvent == 5'h00
         |=> status_r == 5'h00 && txByte_r == {3'h0, $past(status_r)};
   endproperty
   a_readClear: assert property (p_readClear) else $error("status read-clear wrong");

   property p_fifoTemp;
      sampleValid && sample.temp == 16'sh0100 |=> fifoTempByte == 8'h04;
   endproperty
   a_fifoTemp: assert property (p_fifoTemp) else $error("fifo temperature scale wrong");

   property p_dataReadOnly;
      wrEn && isDataAddr(addr_r) |=> fsCfg_r == $past(fsCfg_r) && selfTest_r == $past(selfTest_r);
   endproperty
   a_dataReadOnly: assert property (p_dataReadOnly) else $error("data write disturbed config");

   c_readBurst:  cover property (ldDly_r[1] ##[1:200] ldDly_r[1]);
   c_selfTest:   cover property (wrEn && addr_r == OFS_SELFTEST);
   c_irqLatched: cover property (intCfg_r.latched && irqLineOneOe && !intCfg_r.pushPull1);
   c_frameSync:  cover property (frameSyncPulse);

endmodule : hsr_host_readout

// file: verification/hsr_spi_host.sv
`timescale 1ns/1ps
module hsr_spi_host (
   // Pins toward the sensor
   output logic csN,
   output logic sclk,
   output logic mosi,
   output logic hostOe,
   input  wire logic miso
);
   // -------------------------------------------------------------
   // Frame of one command byte and one data byte, mode 0, MSB first
   // -------------------------------------------------------------
   initial begin
      csN = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
      hostOe = 1'b1;
   end

   // Long low phase: the sensor's read bit lands some 24 to 29 ns after the fall
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] wr, output logic [7:0] rd);
      logic [15:0] sh;
      sh = {cmd, wr};
      hostOe = 1'b1;
      csN = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         mosi = sh[i];
         #62.5;
         sclk = 1'b1;
         rd = {rd[6:0], miso};
         #62.5;
         sclk = 1'b0;
         // Turn the shared pin round only after the last command bit was taken
         if (i == 8 && cmd[7]) hostOe = 1'b0;
      end
      #62.5;
      csN = 1'b1;
      #125;
   endtask : xfer
endmodule : hsr_spi_host

// file: verification/hsr_host_readout_tb_top.sv
`timescale 1ns/1ps
module hsr_host_readout_tb_top;
   import hsr_pkg::*;
   logic core_clk = 1'b0, srst = 1'b1, strap = 1'b0, fsIn = 1'b0, sValid = 1'b0, threeWire = 1'b0;
   logic [4:0] irqEvent = 5'h00;
   hsr_sample_s smp = '0;
   logic csN, sclk, mosi, hOe, dOut, dOe, sOut, sOe, twoW, strapOut, i1o, i1e, i2o, i2e, fsPulse;
   logic [7:0] fifoT, rd;
   logic [5:0] stEn;
   hsr_gyro_fs_e gfs;
   hsr_accel_fs_e afs;
   hsr_clk_src_e csrc;
   int n_fail = 0, n_compared = 0, cnt;
   // Released pin shows the inverse of the host's current mosi level rather than a guess
   wire pin14 = dOe ? dOut : (hOe ? mosi : ~mosi);
   wire pin1 = sOe ? sOut : strap;
   always #5 core_clk = ~core_clk;

   hsr_host_readout uut (
      .core_clk(core_clk), .srst(srst), .hostChipSelectN(csN), .hostSpiClock(sclk),
      .hostBidirDataIn(pin14), .hostBidirDataOut(dOut), .hostBidirDataOe(dOe),
      .addrLsbStrapIn(pin1), .hostSerialOut(sOut), .hostSerialOutOe(sOe),
      .twoWireMode(twoW), .addrLsbStrap(strapOut), .irqLineOneOut(i1o), .irqLineOneOe(i1e),
      .irqLineTwoOut(i2o), .irqLineTwoOe(i2e), .frameSyncInput(fsIn), .frameSyncPulse(fsPulse),
      .sample(smp), .sampleValid(sValid), .irqEvent(irqEvent), .fifoTempByte(fifoT),
      .gyroFsSel(gfs), .accelFsSel(afs), .clkSrcSel(csrc), .selfTestEn(stEn)
   );
   hsr_spi_host host (.csN(csN), .sclk(sclk), .mosi(mosi), .hostOe(hOe), .miso(threeWire ? pin14 : pin1));

   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] x;
      // Start off the clock edge so no link pin changes as the core samples
      @(posedge core_clk);
      #1;
      host.xfer({1'b0, a}, d, x);
   endtask : wr
   task automatic rdr(input logic [6:0] a, output logic [7:0] d);
      @(posedge core_clk);
      #1;
      host.xfer({1'b1, a}, 8'h00, d);
   endtask : rdr
   task automatic pulse(input logic [4:0] e);
      @(posedge core_clk);
      irqEvent <= e;
      @(posedge core_clk);
      irqEvent <= 5'h00;
      repeat (3) @(posedge core_clk);
   endtask : pulse
   task automatic finish_test;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   // -------------------------------------------------------------
   // Tests
   // -------------------------------------------------------------
   initial begin
      #500us;
      n_fail++;
      finish_test();
   end
   initial begin
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk("two wire", {7'h0, twoW}, 8'h01);
      chk("clock source", {7'h0, csrc}, 8'h01);
      strap <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk("addr lsb", {7'h0, strapOut}, 8'h01);
      for (int i = 0; i < 8; i++) begin
         wr(OFS_FS_CFG, {2'b00, 2'(i), 1'b0, 3'(i)});
         chk("gyro fs", {5'h0, gfs}, 8'(i));
         chk("accel fs", {6'h0, afs}, 8'(i % 4));
      end
      chk("two wire off", {7'h0, twoW}, 8'h00);
      wr(OFS_CLK_CFG, 8'h00);
      chk("clock source", {7'h0, csrc}, 8'h00);
      wr(OFS_SELFTEST, 8'h2a);
      chk("self test", {2'h0, stEn}, 8'h2a);
      @(posedge core_clk);
      smp <= 112'hfc00_1234_5678_9abc_def0_0f1e_2d3c;
      sValid <= 1'b1;
      @(posedge core_clk);
      sValid <= 1'b0;
      wr(7'h00, 8'h55);
      for (int a = 0; a < DATA_BYTES; a++) begin
         rdr(7'(a), rd);
         chk("data byte", rd, smp[111 - 8 * a -: 8]);
      end
      chk("fifo temp", fifoT, 8'hf0);
      // Self-test on: the sensor side shifts gyro X, the host takes the difference
      @(posedge core_clk);
      smp.temp <= 16'sh0100;
      smp.gyroX <= smp.gyroX + 16'sh0100;
      sValid <= 1'b1;
      @(posedge core_clk);
      sValid <= 1'b0;
      rdr(7'h08, rd);
      chk("self test response", 8'(rd - 8'hde), 8'h01);
      chk("fifo temp small", fifoT, 8'h04);
      wr(OFS_IF_CFG, 8'h01);
      threeWire = 1'b1;
      rdr(OFS_FS_CFG, rd);
      chk("three wire read", rd, 8'h37);
      chk("serial out idle", {7'h0, sOe}, 8'h00);
      wr(OFS_IF_CFG, 8'h00);
      threeWire = 1'b0;
      wr(OFS_IRQ_LINE_ONE_EN, 8'h1f);
      wr(OFS_INT_CFG, 8'h05);
      for (int s = 0; s < NUM_SRC; s++) begin
         pulse(5'(1 << s));
         chk("irq one active", {6'h0, i1e, i1o}, 8'h03);
         rdr(OFS_INT_STATUS, rd);
         chk("status", rd, 8'(1 << s));
         wr(OFS_INT_STATUS, 8'(1 << s));
         rdr(OFS_INT_STATUS, rd);
         chk("status cleared", rd, 8'h00);
         chk("irq one idle", {6'h0, i1e, i1o}, 8'h02);
      end
      wr(OFS_IRQ_LINE_TWO_EN, 8'h10);
      wr(OFS_INT_CFG, 8'h0c);
      pulse(5'h10);
      chk("irq one drain", {6'h0, i1e, i1o}, 8'h02);
      chk("irq two drain", {6'h0, i2e, i2o}, 8'h02);
      rdr(OFS_INT_STATUS, rd);
      chk("status", rd, 8'h10);
      rdr(OFS_INT_STATUS, rd);
      chk("read clear", rd, 8'h00);
      chk("irq one released", {6'h0, i1e, i1o}, 8'h00);
      wr(OFS_INT_CFG, 8'h10);
      chk("line two input", {6'h0, i2e, i2o}, 8'h00);
      // Unlatched open-drain: line one pulls low for the event cycle only
      @(posedge core_clk);
      irqEvent <= 5'h01;
      @(posedge core_clk);
      irqEvent <= 5'h00;
      @(negedge core_clk);
      chk("irq one pulse", {6'h0, i1e, i1o}, 8'h02);
      @(negedge core_clk);
      chk("irq one pulse end", {6'h0, i1e, i1o}, 8'h00);
      @(posedge core_clk);
      fsIn <= 1'b1;
      cnt = 0;
      repeat (12) begin
         @(negedge core_clk);
         cnt += fsPulse;
      end
      chk("frame sync pulses", 8'(cnt), 8'h01);
      finish_test();
   end
endmodule : hsr_host_readout_tb_top
